/* hdl/boc_pkg.sv */
// shared constants of the beam output conditioner
package boc_pkg;
    localparam int          NBEAM        = 32;
    localparam int          NOUT         = 4;
    // register byte offsets
    localparam logic [7:0]  OFS_CTRL     = 8'h00;
    localparam logic [7:0]  OFS_POL      = 8'h04;
    localparam logic [7:0]  OFS_LINK     = 8'h08;
    localparam logic [7:0]  OFS_TEACH    = 8'h0c;
    localparam logic [7:0]  OFS_STAT     = 8'h10;
    localparam logic [7:0]  OFS_BEAMS    = 8'h14;
    localparam logic [7:0]  OFS_MASK0    = 8'h20;
    localparam logic [7:0]  OFS_TF0      = 8'h30;
    // field positions
    localparam int          CTRL_TRIG    = 4;
    localparam int          CTRL_CNT_LSB = 8;
    localparam int          TEACH_GO     = 8;
    localparam int          STAT_READY   = 0;
    localparam int          STAT_DONE    = 1;
    localparam int          STAT_ERR     = 2;
    localparam int          STAT_OUT_LSB = 4;
    localparam int          TF_FUNC_LSB  = 16;
    // reset values
    localparam logic [3:0]  RST_DEPTH    = 4'h1;
    localparam logic [5:0]  RST_BCNT     = 6'h20;
    localparam logic [3:0]  RST_POL      = 4'h0;
    // timing
    localparam int          CLK_NS       = 50;
    localparam int          MS_NS        = 1000000;
    localparam int          MS_CYC       = MS_NS / CLK_NS;
    localparam logic [15:0] TF_MAX_MS    = 16'hfde8;
    // time function selection
    typedef enum logic [2:0] {
        TF_NONE    = 3'b000,
        TF_ON_DLY  = 3'b001,
        TF_OFF_DLY = 3'b010,
        TF_STRETCH = 3'b011,
        TF_SUPPR   = 3'b100
    } boc_tf_t;
endpackage

/* hdl/boc_time_func.sv */
// one switching output time function stage
`timescale 1ns/100ps
`default_nettype none
module boc_time_func (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        eval,
    input  wire logic        ms_tick,
    input  wire logic [2:0]  func,
    input  wire logic [15:0] dur_ms,
    input  wire logic        lvl_in,
    output logic             lvl_out
);
    logic        prev_q;
    logic        out_q;
    logic [15:0] cnt_q;
    logic [15:0] cnt_inc;
    logic        delayed;
    logic        retrig;
    logic        ripe;

    // which transitions are held back; stretching holds every change of the output
    always_comb begin
        delayed = 1'b0;
        retrig  = 1'b1;
        case (func)
            boc_pkg::TF_ON_DLY:  delayed = lvl_in;
            boc_pkg::TF_OFF_DLY: delayed = ~lvl_in;
            boc_pkg::TF_STRETCH: begin
                delayed = 1'b1;
                retrig  = 1'b0;
            end
            boc_pkg::TF_SUPPR:   delayed = 1'b1;
            default:             delayed = 1'b0;
        endcase
    end

    // saturating millisecond count, compared only at evaluation time
    assign cnt_inc = (ms_tick && cnt_q != 16'hffff) ? cnt_q + 16'h0001 : cnt_q;
    assign ripe    = ~delayed || (cnt_inc >= dur_ms);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev_q <= 1'b0;
            out_q  <= 1'b0;
            cnt_q  <= 16'h0000;
        end else if (eval) begin
            prev_q <= lvl_in;
            if (retrig && delayed && lvl_in != prev_q) begin
                cnt_q <= 16'h0000;
            end else if (lvl_in != out_q && ripe) begin
                out_q <= lvl_in;
                cnt_q <= 16'h0000;
            end else begin
                cnt_q <= cnt_inc;
            end
        end else begin
            cnt_q <= cnt_inc;
        end
    end

    assign lvl_out = out_q;
endmodule
`default_nettype wire

/* hdl/boc_top.sv */
// beam output conditioner: filter, height teach, areas, polarity, time functions
//
// Register access over AHB-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - a beam state change passes on only after holding for depth cycles
// - depth one forwards every cycle's beam states unchanged
// - depth three forwards a change after three stable cycles
// - up to four taught height areas, one per output
// - panel teach with object: free beams beside the edge object form the area
// - teach with all beams free learns the whole beam range
// - taught height areas use OR linking until the link register is next written
// - software teach with beams interrupted reports an error, no teach
// - panel teach assigns the next output pin to the learned area
// - after reset every output has normal polarity
// - normal polarity: high while all beams free, low when interrupted
// - normal polarity: linked area result one gives high output
// - inverted polarity: low when all interrupted, high when beams free
// - inverted polarity: linked area result one gives low output
// - each output has its own single selected time function
// - retriggerable switch-on delay up to 65000 ms
// - retriggerable switch-off delay up to 65000 ms
// - pulse stretching holds each new output state for the duration
// - pulse suppression passes only states lasting the duration
// - delays are resolved in whole measurement cycles
// - ready withheld while trigger mode on and no trigger pulse seen
// - areas work on the logical beam count
// - OR area bit one when any mapped beam is interrupted
// - AND area bit one only when all mapped beams are interrupted
module boc_top #(
    parameter int MS_CYCLES = boc_pkg::MS_CYC
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        meas_strobe,
    input  wire logic [31:0] beam_raw,
    input  wire logic        trig_pulse,
    input  wire logic        panel_teach,
    output logic             meas_ready,
    output logic             switch_output_one,
    output logic             switch_output_two,
    output logic             switch_output_three,
    output logic             switch_output_four
);
    localparam int NB = boc_pkg::NBEAM;
    localparam int NO = boc_pkg::NOUT;

    // configuration and status state
    logic [3:0]    depth_q;
    logic          trig_en_q;
    logic [5:0]    bcnt_q;
    logic [3:0]    pol_q;
    logic [3:0]    link_and_q;
    logic [NB-1:0] mask_q [NO];
    logic [15:0]   dur_q [NO];
    logic [2:0]    func_q [NO];
    logic          done_q;
    logic          err_q;
    logic          sw_go_q;
    logic [1:0]    sw_idx_q;
    logic          pan_go_q;
    logic [1:0]    pan_idx_q;
    logic          trig_seen_q;
    logic [NB-1:0] filt_q;
    logic [3:0]    fcnt_q [NB];
    logic          eval_q;
    logic [15:0]   ms_cnt_q;
    logic          ms_tick;
    logic [NO-1:0] tf_out;

    // bus data phase state
    logic          dp_wr_q;
    logic [7:0]    dp_addr_q;
    logic [31:0]   rdata_q;
    logic          addr_ok;
    logic          wr_en;
    logic [31:0]   rd_mux;

    // ------------------------------------------------------------------
    // ahb-lite slave, zero wait states, always okay
    assign addr_ok   = hsel && hready && htrans[1];
    assign wr_en     = dp_wr_q;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rdata_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr_q   <= 1'b0;
            dp_addr_q <= 8'h00;
        end else begin
            dp_wr_q   <= addr_ok && hwrite;
            dp_addr_q <= haddr[7:0];
        end
    end

    // read data taken at the address phase so it stands in the data phase
    always_comb begin
        rd_mux = 32'h0000_0000;
        case ({haddr[31:8] == 24'h000000, haddr[7:0]})
            {1'b1, boc_pkg::OFS_CTRL}:  rd_mux = {18'h00000, bcnt_q, 3'h0, trig_en_q, depth_q};
            {1'b1, boc_pkg::OFS_POL}:   rd_mux = {28'h0000000, pol_q};
            {1'b1, boc_pkg::OFS_LINK}:  rd_mux = {28'h0000000, link_and_q};
            {1'b1, boc_pkg::OFS_TEACH}: rd_mux = {23'h000000, sw_go_q | pan_go_q, 6'h00, pan_idx_q};
            {1'b1, boc_pkg::OFS_STAT}:  rd_mux = {24'h000000, tf_out ^ pol_q, 1'b0, err_q, done_q, meas_ready};
            {1'b1, boc_pkg::OFS_BEAMS}: rd_mux = filt_q;
            default: begin
                if (haddr[31:6] == 26'h0 && haddr[5:4] == 2'b10 && haddr[1:0] == 2'b00) begin
                    rd_mux = mask_q[haddr[3:2]];
                end else if (haddr[31:6] == 26'h0 && haddr[5:4] == 2'b11 && haddr[1:0] == 2'b00) begin
                    rd_mux = {13'h0000, func_q[haddr[3:2]], dur_q[haddr[3:2]]};
                end
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_q <= 32'h0000_0000;
        end else if (addr_ok && !hwrite) begin
            rdata_q <= rd_mux;
        end
    end

    // ------------------------------------------------------------------
    // plain control registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            depth_q   <= boc_pkg::RST_DEPTH;
            trig_en_q <= 1'b0;
            bcnt_q    <= boc_pkg::RST_BCNT;
            pol_q     <= boc_pkg::RST_POL;
        end else if (wr_en) begin
            if (dp_addr_q == boc_pkg::OFS_CTRL) begin
                depth_q   <= hwdata[3:0];
                trig_en_q <= hwdata[boc_pkg::CTRL_TRIG];
                bcnt_q    <= hwdata[boc_pkg::CTRL_CNT_LSB +: 6];
            end
            if (dp_addr_q == boc_pkg::OFS_POL) begin
                pol_q <= hwdata[3:0];
            end
        end
    end

    // per output time function settings, duration clamped to the maximum
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int k = 0; k < NO; k++) begin
                dur_q[k]  <= 16'h0000;
                func_q[k] <= boc_pkg::TF_NONE;
            end
        end else if (wr_en && dp_addr_q[7:4] == boc_pkg::OFS_TF0[7:4] && dp_addr_q[1:0] == 2'b00) begin
            func_q[dp_addr_q[3:2]] <= hwdata[boc_pkg::TF_FUNC_LSB +: 3];
            dur_q[dp_addr_q[3:2]]  <= (hwdata[15:0] > boc_pkg::TF_MAX_MS) ?
                                      boc_pkg::TF_MAX_MS : hwdata[15:0];
        end
    end

    // ------------------------------------------------------------------
    // millisecond tick divider
    assign ms_tick = (ms_cnt_q == 16'(MS_CYCLES - 1));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ms_cnt_q <= 16'h0000;
        end else if (ms_tick) begin
            ms_cnt_q <= 16'h0000;
        end else begin
            ms_cnt_q <= ms_cnt_q + 16'h0001;
        end
    end

    // ------------------------------------------------------------------
    // stability filter per beam; depth zero behaves as one
    logic [NB-1:0] valid_mask;

    generate
        for (genvar b = 0; b < NB; b++) begin : g_filt
            logic [3:0] nxt;
            assign nxt = fcnt_q[b] + 4'h1;
            assign valid_mask[b] = (6'(b) < bcnt_q);
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    filt_q[b] <= 1'b0;
                    fcnt_q[b] <= 4'h0;
                end else if (meas_strobe) begin
                    if (beam_raw[b] == filt_q[b]) begin
                        fcnt_q[b] <= 4'h0;
                    end else if (nxt >= depth_q) begin
                        filt_q[b] <= beam_raw[b];
                        fcnt_q[b] <= 4'h0;
                    end else begin
                        fcnt_q[b] <= nxt;
                    end
                end
            end
        end
    endgenerate

    // evaluation runs one clock after the filter has taken the cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            eval_q <= 1'b0;
        end else begin
            eval_q <= meas_strobe;
        end
    end

    // ------------------------------------------------------------------
    // height teach: find first and last interrupted logical beam
    logic [NB-1:0] blk;
    logic [NB-1:0] teach_mask;
    logic [5:0]    fib;
    logic [5:0]    lib;
    logic          any_blk;
    logic          edge_ok;

    assign blk     = filt_q & valid_mask;
    assign any_blk = |blk;

    always_comb begin
        fib = 6'h00;
        lib = 6'h00;
        for (int b = NB - 1; b >= 0; b--) begin
            if (blk[b]) fib = 6'(b);
        end
        for (int b = 0; b < NB; b++) begin
            if (blk[b]) lib = 6'(b);
        end
    end

    // object must sit on the first or the last beam
    assign edge_ok = blk[0] || blk[5'(bcnt_q - 6'h01)];

    always_comb begin
        teach_mask = '0;
        for (int b = 0; b < NB; b++) begin
            if (!any_blk) begin
                teach_mask[b] = valid_mask[b];
            end else if (blk[0]) begin
                teach_mask[b] = valid_mask[b] && (6'(b) > lib);
            end else begin
                teach_mask[b] = valid_mask[b] && (6'(b) < fib);
            end
        end
    end

    // teach requests wait for the next evaluation; done and error clear by writing one
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sw_go_q   <= 1'b0;
            sw_idx_q  <= 2'b00;
            pan_go_q  <= 1'b0;
            pan_idx_q <= 2'b00;
            done_q    <= 1'b0;
            err_q     <= 1'b0;
        end else begin
            if (wr_en && dp_addr_q == boc_pkg::OFS_STAT) begin
                if (hwdata[boc_pkg::STAT_DONE]) done_q <= 1'b0;
                if (hwdata[boc_pkg::STAT_ERR])  err_q  <= 1'b0;
            end
            if (wr_en && dp_addr_q == boc_pkg::OFS_TEACH && hwdata[boc_pkg::TEACH_GO]) begin
                sw_go_q  <= 1'b1;
                sw_idx_q <= hwdata[1:0];
            end
            if (panel_teach) begin
                pan_go_q <= 1'b1;
            end
            if (eval_q && sw_go_q) begin
                sw_go_q <= 1'b0;
                if (any_blk) err_q <= 1'b1;
                else         done_q <= 1'b1;
            end else if (eval_q && pan_go_q) begin
                pan_go_q <= 1'b0;
                if (any_blk && !edge_ok) begin
                    err_q <= 1'b1;
                end else begin
                    done_q    <= 1'b1;
                    pan_idx_q <= pan_idx_q + 2'b01;
                end
            end
        end
    end

    // area masks and link kind; a taught area is forced to or linking
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            link_and_q <= 4'h0;
            for (int k = 0; k < NO; k++) begin
                mask_q[k] <= '0;
            end
        end else if (eval_q && sw_go_q) begin
            if (!any_blk) begin
                mask_q[sw_idx_q]     <= teach_mask;
                link_and_q[sw_idx_q] <= 1'b0;
            end
        end else if (eval_q && pan_go_q) begin
            if (!any_blk || edge_ok) begin
                mask_q[pan_idx_q]     <= teach_mask;
                link_and_q[pan_idx_q] <= 1'b0;
            end
        end else if (wr_en) begin
            if (dp_addr_q == boc_pkg::OFS_LINK) begin
                link_and_q <= hwdata[3:0];
            end
            if (dp_addr_q[7:4] == boc_pkg::OFS_MASK0[7:4] && dp_addr_q[1:0] == 2'b00) begin
                mask_q[dp_addr_q[3:2]] <= hwdata;
            end
        end
    end

    // ------------------------------------------------------------------
    // area logic, polarity and time function per output
    logic [NO-1:0] lvl;

    always_comb begin
        for (int k = 0; k < NO; k++) begin
            logic [NB-1:0] m;
            logic          area;
            m    = mask_q[k] & valid_mask;
            area = link_and_q[k] ? &(blk | ~m)
                                 : |(blk & m);
            if (m == '0) begin
                // no area mapped: whole field decides
                lvl[k] = pol_q[k] ? ~&(filt_q | ~valid_mask)
                                  : ~any_blk;
            end else begin
                lvl[k] = area;
            end
        end
    end

    generate
        for (genvar k = 0; k < NO; k++) begin : g_tf
            boc_time_func u_tf (
                .hclk    (hclk),
                .hresetn (hresetn),
                .eval    (eval_q),
                .ms_tick (ms_tick),
                .func    (func_q[k]),
                .dur_ms  (dur_q[k]),
                .lvl_in  (lvl[k]),
                .lvl_out (tf_out[k])
            );
        end
    endgenerate

    // inversion after timing for linked areas only; plain mode applies polarity before timing
    logic [NO-1:0] pins;
    always_comb begin
        for (int k = 0; k < NO; k++) begin
            pins[k] = (mask_q[k] & valid_mask) == '0 ? tf_out[k]
                                                     : tf_out[k] ^ pol_q[k];
        end
    end

    assign switch_output_one   = pins[0];
    assign switch_output_two   = pins[1];
    assign switch_output_three = pins[2];
    assign switch_output_four  = pins[3];

    // ------------------------------------------------------------------
    // ready: withheld in trigger mode until a trigger pulse has been seen
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            trig_seen_q <= 1'b0;
        end else if (trig_pulse) begin
            trig_seen_q <= 1'b1;
        end
    end

    assign meas_ready = ~trig_en_q | trig_seen_q;
endmodule
`default_nettype wire

/* tb/boc_plc_model.sv */
// controller model: latches output image, debounces ready
`timescale 1ns/100ps
`default_nettype none
module boc_plc_model #(
    parameter int DEB_CYC = 4
) (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       meas_ready,
    input  wire logic [3:0] sw,
    output logic      [3:0] img,
    output logic            ready_ok
);
    int cnt_q;
    // input image taken once per controller cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            img <= 4'h0;
        end else begin
            img <= sw;
        end
    end
    // ready trusted only after a steady wait; a glitch restarts it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= 0;
            ready_ok <= 1'b0;
        end else if (!meas_ready) begin
            cnt_q <= 0;
            ready_ok <= 1'b0;
        end else if (cnt_q < DEB_CYC) begin
            cnt_q <= cnt_q + 1;
        end else begin
            ready_ok <= 1'b1;
        end
    end
endmodule
`default_nettype wire

/* tb/boc_top_properties.sv */
// concurrent checks on the beam output conditioner ports
`timescale 1ns/100ps
`default_nettype none
module boc_top_properties (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic        hready,
    input  wire logic        hreadyout,
    input  wire logic        hresp,
    input  wire logic [31:0] hrdata,
    input  wire logic        meas_strobe,
    input  wire logic        trig_pulse,
    input  wire logic        meas_ready,
    input  wire logic        switch_output_one,
    input  wire logic        switch_output_two,
    input  wire logic        switch_output_three,
    input  wire logic        switch_output_four
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // bus handshake: zero wait, always okay
    property p_no_wait; hreadyout; endproperty
    a_no_wait: assert property (p_no_wait) else $error("slave inserted wait");
    property p_okay; !hresp; endproperty
    a_okay: assert property (p_okay) else $error("slave gave error response");
    // read data only moves after a read address phase
    property p_rdata_hold; $changed(hrdata) |-> $past(hsel && hready && htrans[1] && !hwrite); endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without read");
    property p_hole; hsel && hready && htrans[1] && !hwrite && haddr == 32'h1c |=> hrdata == 32'h0; endproperty
    a_hole: assert property (p_hole) else $error("unmapped read not zero");
    property p_stat_ready; hsel && hready && htrans[1] && !hwrite && haddr == 32'h10 |=> hrdata[0] == $past(meas_ready); endproperty
    a_stat_ready: assert property (p_stat_ready) else $error("status ready bit mismatch");
    property p_trig_ready; trig_pulse |=> meas_ready; endproperty
    a_trig_ready: assert property (p_trig_ready) else $error("ready missing after trigger");
    property p_ready_fall; $fell(meas_ready) |-> $past(hsel && htrans[1] && hwrite, 2); endproperty
    a_ready_fall: assert property (p_ready_fall) else $error("ready dropped without config");
    // outputs move only at an evaluation two edges after a strobe or a write
    property p_out_cause;
        $changed({switch_output_one, switch_output_two, switch_output_three, switch_output_four})
            |-> $past(meas_strobe, 2) || $past(hsel && htrans[1] && hwrite, 2);
    endproperty
    a_out_cause: assert property (p_out_cause) else $error("output moved off cycle");
endmodule
bind boc_top boc_top_properties u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .meas_strobe(meas_strobe), .trig_pulse(trig_pulse), .meas_ready(meas_ready),
    .switch_output_one(switch_output_one), .switch_output_two(switch_output_two),
    .switch_output_three(switch_output_three), .switch_output_four(switch_output_four));
`default_nettype wire

/* tb/boc_top_tb.sv */
// self-checking bench of the beam output conditioner
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, s) begin checks++; if ((s) !== (e)) begin errors++; $display("BAD %s exp %h got %h", nm, e, s); end end
module boc_top_tb;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        meas_strobe = 1'b0;
    logic [31:0] beam_raw = 32'h0;
    logic        trig_pulse = 1'b0;
    logic        panel_teach = 1'b0;
    logic        meas_ready;
    logic [3:0]  sw;
    logic [3:0]  img;
    logic        ready_ok;
    logic [31:0] rd;
    int          errors = 0;
    int          checks = 0;
    always #25 hclk = ~hclk;
    // ms scaled down to 10 cycles to keep delays short
    boc_top #(.MS_CYCLES(10)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .meas_strobe(meas_strobe),
        .beam_raw(beam_raw), .trig_pulse(trig_pulse), .panel_teach(panel_teach), .meas_ready(meas_ready),
        .switch_output_one(sw[0]), .switch_output_two(sw[1]), .switch_output_three(sw[2]),
        .switch_output_four(sw[3]));
    boc_plc_model #(.DEB_CYC(4)) plc (.hclk(hclk), .hresetn(hresetn), .meas_ready(meas_ready), .sw(sw),
        .img(img), .ready_ok(ready_ok));
    // verdict and end of run
    task automatic close_out;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // wait for hready at a rising edge, bounded
    task automatic wait_rdy;
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 50) begin
                errors++;
                close_out;
            end
            @(posedge hclk);
        end
    endtask
    // one single word transfer, read data left in rd
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        wait_rdy;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy;
        rd = hrdata;
    endtask
    // one measurement cycle, then let evaluation and image settle
    task automatic beam(input logic [31:0] v);
        beam_raw <= v;
        meas_strobe <= 1'b1;
        @(posedge hclk);
        meas_strobe <= 1'b0;
        repeat (4) @(posedge hclk);
    endtask
    initial begin
        repeat (20000) @(posedge hclk);
        errors++;
        close_out;
    end
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(0, 8'h00, 32'h0); `CHK("ctrl", 32'h00002001, rd & 32'h3f1f)
        bus(0, 8'h04, 32'h0); `CHK("pol", 32'h0, rd & 32'hf)
        bus(0, 8'h1c, 32'h0); `CHK("hole", 32'h0, rd)
        beam(32'h0); `CHK("o1 free", 1'b1, img[0])
        beam(32'h100); `CHK("o1 cut", 1'b0, img[0])
        bus(1, 8'h04, 32'h2);
        beam(32'h100); `CHK("o2 part", 1'b1, img[1])
        beam(32'hffffffff); `CHK("o2 all", 1'b0, img[1])
        bus(1, 8'h04, 32'h0);
        // depth three: change shows on the third equal cycle only
        bus(1, 8'h00, 32'h2003);
        repeat (3) beam(32'h0);
        for (int i = 1; i <= 3; i++) begin
            beam(32'h1); `CHK("filt", (i == 3) ? 1'b0 : 1'b1, img[0])
        end
        bus(0, 8'h14, 32'h0); `CHK("beams", 32'h1, rd)
        bus(1, 8'h00, 32'h2001);
        // area on output one, OR then AND, then inverted
        bus(1, 8'h20, 32'hf);
        beam(32'h10); `CHK("or0", 1'b0, img[0])
        beam(32'h4); `CHK("or1", 1'b1, img[0])
        bus(1, 8'h08, 32'h3);
        beam(32'h7); `CHK("and0", 1'b0, img[0])
        beam(32'hf); `CHK("and1", 1'b1, img[0])
        bus(1, 8'h04, 32'h1);
        beam(32'hf); `CHK("inv1", 1'b0, img[0])
        bus(1, 8'h04, 32'h0);
        // software teach refused while beams cut, then learns all beams
        bus(1, 8'h0c, 32'h101);
        beam(32'hf);
        bus(0, 8'h10, 32'h0); `CHK("sw err", 1'b1, rd[2])
        bus(0, 8'h24, 32'h0); `CHK("no mask", 32'h0, rd)
        bus(1, 8'h10, 32'h6);
        beam(32'h0);
        bus(1, 8'h0c, 32'h101);
        beam(32'h0);
        bus(0, 8'h10, 32'h0); `CHK("sw ok", 2'b01, rd[2:1])
        bus(0, 8'h24, 32'h0); `CHK("all", 32'hffffffff, rd)
        bus(0, 8'h08, 32'h0); `CHK("or", 1'b0, rd[1])
        // panel teach with object at beam 0 lands on output one
        beam(32'hf);
        panel_teach <= 1'b1;
        @(posedge hclk);
        panel_teach <= 1'b0;
        beam(32'hf);
        bus(0, 8'h20, 32'h0); `CHK("panel", 32'hfffffff0, rd)
        bus(0, 8'h0c, 32'h0); `CHK("next", 2'h1, rd[1:0])
        // on-delay of 2 ms on output three
        bus(1, 8'h38, 32'h00010002);
        beam(32'hffffffff);
        beam(32'h0); `CHK("ondly", 1'b0, img[2])
        repeat (8) beam(32'h0);
        `CHK("on", 1'b1, img[2])
        // output four: off-delay, stretch, suppression
        bus(1, 8'h3c, 32'h00020002);
        beam(32'hffffffff); `CHK("offdly", 1'b1, img[3])
        repeat (8) beam(32'hffffffff);
        `CHK("off", 1'b0, img[3])
        bus(1, 8'h3c, 32'h00030002);
        beam(32'h0);
        beam(32'hffffffff); `CHK("stretch", 1'b1, img[3])
        bus(1, 8'h3c, 32'h00040002);
        beam(32'h0);
        beam(32'hffffffff); `CHK("suppr", 1'b1, img[3])
        // trigger mode withholds ready until a pulse
        bus(1, 8'h00, 32'h2011);
        repeat (6) @(posedge hclk);
        `CHK("nordy", 1'b0, meas_ready)
        `CHK("plc0", 1'b0, ready_ok)
        trig_pulse <= 1'b1;
        @(posedge hclk);
        trig_pulse <= 1'b0;
        repeat (2) @(posedge hclk);
        `CHK("rdy", 1'b1, meas_ready)
        repeat (8) @(posedge hclk);
        `CHK("plc1", 1'b1, ready_ok)
        close_out;
    end
endmodule
`default_nettype wire
